// file: rtl/amioc_pkg.sv
// Shared constants and types of the analog IO mode controller
package amioc_pkg;
  // Data widths and trigger count
  localparam int DW = 32;
  localparam int MIDW = 8;
  localparam int NTRIG = 3;
  // Current loop end points in microamps
  localparam logic signed [DW-1:0] CUR_TOP_UA = 32'sh0000_4e20;
  localparam logic signed [DW-1:0] CUR_LOW4_UA = 32'sh0000_0fa0;
  localparam logic signed [DW-1:0] CUR_LOW0_UA = 32'sh0000_0000;
  localparam logic signed [DW-1:0] VAL_ZERO = 32'sh0000_0000;
  // Motor operating mode codes
  localparam logic [3:0] OPM_SLEEP = 4'h0;
  localparam logic [3:0] OPM_FORCE = 4'h8;
  localparam logic [3:0] OPM_POS = 4'h9;
  localparam logic [3:0] OPM_KIN = 4'ha;
  // Configured mode selection codes
  localparam logic [1:0] CFG_FORCE = 2'h0;
  localparam logic [1:0] CFG_POS = 2'h1;
  localparam logic [1:0] CFG_KIN = 2'h2;
  // Controller states, one-hot
  typedef enum logic [3:0] {
    ST_SLEEP = 4'h1,
    ST_FORCE = 4'h2,
    ST_POS = 4'h4,
    ST_KIN = 4'h8
  } amioc_state_t;
endpackage : amioc_pkg

// file: rtl/amioc_lmap.sv
// Clamped linear range mapper with registered result
`timescale 1ns/10ps
`default_nettype none
module amioc_lmap
  import amioc_pkg::*;
#(
  parameter int W = DW
) (
  // Clock, reset and enable
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // Value and ranges
  input wire logic signed [W-1:0] x_i,
  input wire logic signed [W-1:0] in_lo_i,
  input wire logic signed [W-1:0] in_hi_i,
  input wire logic signed [W-1:0] out_lo_i,
  input wire logic signed [W-1:0] out_hi_i,
  // Mapped value
  output logic signed [W-1:0] y_o
);
  typedef struct packed {
    logic signed [W-1:0] y;
  } amioc_lmap_st_t;
  amioc_lmap_st_t st_r;
  amioc_lmap_st_t st_nxt;
  logic signed [W-1:0] xc;
  logic signed [W:0] dx;
  logic signed [W:0] span_in;
  logic signed [W:0] span_out;
  logic signed [2*W+1:0] prod;
  // Clip input to its range, then scale into the output range
  always_comb begin
    st_nxt = st_r;
    xc = (x_i < in_lo_i) ? in_lo_i : ((x_i > in_hi_i) ? in_hi_i : x_i);
    dx = $signed({xc[W-1], xc}) - $signed({in_lo_i[W-1], in_lo_i});
    span_in = $signed({in_hi_i[W-1], in_hi_i}) - $signed({in_lo_i[W-1], in_lo_i});
    span_out = $signed({out_hi_i[W-1], out_hi_i}) - $signed({out_lo_i[W-1], out_lo_i});
    prod = (2*W+2)'(dx) * (2*W+2)'(span_out);
    if (span_in <= $signed((W+1)'(0))) begin
      st_nxt.y = out_lo_i; // Degenerate range
    end else begin
      st_nxt.y = W'(prod / (2*W+2)'(span_in) + (2*W+2)'(out_lo_i));
    end
  end
  // State register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else if (clk_en_i) begin
      st_r <= st_nxt;
    end
  end
  assign y_o = st_r.y;
endmodule : amioc_lmap
`default_nettype wire

// file: rtl/amioc_trig.sv
// Trigger edge detector and motion launch queue
`timescale 1ns/10ps
`default_nettype none
module amioc_trig
  import amioc_pkg::*;
(
  // Clock, reset and enable
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // Trigger inputs and setup
  input wire logic arm_i,
  input wire logic [NTRIG-1:0] trig_i,
  input wire logic [NTRIG-1:0] both_i,
  input wire logic [NTRIG*MIDW-1:0] rise_id_i,
  input wire logic [NTRIG*MIDW-1:0] fall_id_i,
  // Launch strobe with motion identifier
  output logic launch_o,
  output logic [MIDW-1:0] id_o
);
  typedef struct packed {
    logic [NTRIG-1:0] prev;
    logic [2*NTRIG-1:0] pend;
    logic launch;
    logic [MIDW-1:0] id;
  } amioc_trig_st_t;
  amioc_trig_st_t st_r;
  amioc_trig_st_t st_nxt;
  logic found;
  // Serve one pending edge per cycle, then record new edges
  always_comb begin
    st_nxt = st_r;
    found = 1'b0;
    st_nxt.launch = 1'b0;
    st_nxt.prev = trig_i;
    for (int k = 0; k < 2*NTRIG; k++) begin
      if (st_r.pend[k] && !found) begin
        found = 1'b1;
        st_nxt.launch = 1'b1;
        st_nxt.pend[k] = 1'b0;
        st_nxt.id = k[0] ? fall_id_i[(k/2)*MIDW +: MIDW] : rise_id_i[(k/2)*MIDW +: MIDW];
      end
    end
    for (int k = 0; k < NTRIG; k++) begin
      if (trig_i[k] && !st_r.prev[k]) begin
        st_nxt.pend[2*k] = arm_i;
      end
      if (!trig_i[k] && st_r.prev[k] && both_i[k]) begin
        st_nxt.pend[2*k+1] = arm_i;
      end
    end
    if (!arm_i) begin
      st_nxt.pend = '0;
    end
  end
  // State register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else if (clk_en_i) begin
      st_r <= st_nxt;
    end
  end
  assign launch_o = st_r.launch;
  assign id_o = st_r.id;
  // Rising edge of trigger one while armed and idle launches its motion
  property p_trig_rise;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    clk_en_i && arm_i && trig_i[0] && !st_r.prev[0] && st_r.pend == '0
      ##1 clk_en_i && arm_i |=> launch_o && id_o == $past(rise_id_i[MIDW-1:0], 1);
  endproperty
  a_trig_rise: assert property (p_trig_rise) else $error("trigger edge not launched");
endmodule : amioc_trig
`default_nettype wire

// file: rtl/amioc_top.sv
// Mode controller turning current loop and digital inputs into motor commands
//
// Overview of operation
// - Enable low keeps motor asleep always
// - Force mode plus enable gives mode 8
// - Position mode plus enable gives mode 9
// - Kinematic mode plus enable gives mode 10
// - Low current end selectable 4 or 0 mA
// - Force range maps to current, clipped ends
// - Position range maps to current, clipped ends
// - Force command scaled from input current
// - Position target scaled from input current
// - Ceiling select in position mode turns input into force ceiling
// - Position controller force clipped at ceiling
// - Position target frozen while ceiling selected
// - Kinematic mode ignores analog, uses triggers
// - Triggers fire on rising or both edges
// - Each edge launches its configured motion
// - Caution output mirrors motor warning
// - Fault output mirrors motor error
// - Fault persists through sleep if error remains
// - Link data independent of configuration
// - Save command commits settings to storage
`timescale 1ns/10ps
`default_nettype none
module amioc_top
  import amioc_pkg::*;
(
  // Clock, reset and enable
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // Digital inputs
  input wire logic trigger_one_input_i,
  input wire logic force_ceiling_select_i,
  input wire logic trigger_three_input_i,
  input wire logic drive_enable_input_i,
  // Measured input loop current in microamps
  input wire logic signed [DW-1:0] input_current_ua_i,
  // Motor feedback
  input wire logic signed [DW-1:0] force_fb_i,
  input wire logic signed [DW-1:0] position_fb_i,
  input wire logic signed [DW-1:0] pos_force_demand_i,
  input wire logic motor_warning_i,
  input wire logic motor_error_i,
  // Configuration
  input wire logic [1:0] cfg_mode_i,
  input wire logic cfg_low_4ma_i,
  input wire logic signed [DW-1:0] force_min_i,
  input wire logic signed [DW-1:0] force_max_i,
  input wire logic signed [DW-1:0] pos_min_i,
  input wire logic signed [DW-1:0] pos_max_i,
  input wire logic [NTRIG-1:0] trig_both_i,
  input wire logic [NTRIG*MIDW-1:0] trig_rise_id_i,
  input wire logic [NTRIG*MIDW-1:0] trig_fall_id_i,
  input wire logic save_cmd_i,
  // Motor commands
  output logic [3:0] op_mode_o,
  output logic signed [DW-1:0] force_cmd_o,
  output logic signed [DW-1:0] position_target_o,
  output logic signed [DW-1:0] force_ceiling_o,
  output logic signed [DW-1:0] pos_force_limited_o,
  output logic motion_launch_o,
  output logic [MIDW-1:0] motion_id_o,
  // Output loops and link data
  output logic signed [DW-1:0] force_loop_ua_o,
  output logic signed [DW-1:0] position_loop_ua_o,
  output logic signed [DW-1:0] link_current_ua_o,
  // Status and storage
  output logic caution_output_o,
  output logic caution_led_yellow_o,
  output logic fault_output_o,
  output logic fault_led_red_o,
  output logic nv_save_o
);
  typedef struct packed {
    amioc_state_t state;
    logic [3:0] op_mode;
    logic signed [DW-1:0] force_cmd;
    logic signed [DW-1:0] pos_tgt;
    logic signed [DW-1:0] ceiling;
    logic ceil_set;
    logic fcs_prev;
    logic signed [DW-1:0] pos_lim;
    logic signed [DW-1:0] f_loop;
    logic signed [DW-1:0] p_loop;
    logic signed [DW-1:0] link_cur;
    logic caution;
    logic fault;
    logic save_prev;
    logic nv_save;
  } amioc_top_st_t;

  localparam amioc_top_st_t ST_RESET = '{state: ST_SLEEP, op_mode: OPM_SLEEP, default: '0};

  amioc_top_st_t st_r;
  amioc_top_st_t st_nxt;
  logic signed [DW-1:0] i_low;
  logic signed [DW-1:0] fmap_y;
  logic signed [DW-1:0] pmap_y;
  logic signed [DW-1:0] smap_y;
  logic signed [DW-1:0] fout_y;
  logic signed [DW-1:0] pout_y;
  logic trig_launch;
  logic [MIDW-1:0] trig_id;

  // Symmetric clip of a force demand to a ceiling
  function automatic logic signed [DW-1:0] amioc_clip(input logic signed [DW-1:0] d,
                                                      input logic signed [DW-1:0] c);
    amioc_clip = (d > c) ? c : ((d < -c) ? -c : d);
  endfunction : amioc_clip

  // Motor mode code for a controller state
  function automatic logic [3:0] amioc_opcode(input amioc_state_t s);
    case (s)
      ST_FORCE: amioc_opcode = OPM_FORCE;
      ST_POS: amioc_opcode = OPM_POS;
      ST_KIN: amioc_opcode = OPM_KIN;
      default: amioc_opcode = OPM_SLEEP;
    endcase
  endfunction : amioc_opcode

  // Low end of the current range
  assign i_low = cfg_low_4ma_i ? CUR_LOW4_UA : CUR_LOW0_UA;

  // Input current to force command
  amioc_lmap u_fmap (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .x_i(input_current_ua_i), .in_lo_i(i_low), .in_hi_i(CUR_TOP_UA),
    .out_lo_i(force_min_i), .out_hi_i(force_max_i), .y_o(fmap_y)
  );

  // Input current to position target
  amioc_lmap u_pmap (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .x_i(input_current_ua_i), .in_lo_i(i_low), .in_hi_i(CUR_TOP_UA),
    .out_lo_i(pos_min_i), .out_hi_i(pos_max_i), .y_o(pmap_y)
  );

  // Input current to force ceiling, from zero up to maximum force
  amioc_lmap u_smap (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .x_i(input_current_ua_i), .in_lo_i(i_low), .in_hi_i(CUR_TOP_UA),
    .out_lo_i(VAL_ZERO), .out_hi_i(force_max_i), .y_o(smap_y)
  );

  // Force feedback to force output loop current
  amioc_lmap u_fout (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .x_i(force_fb_i), .in_lo_i(force_min_i), .in_hi_i(force_max_i),
    .out_lo_i(i_low), .out_hi_i(CUR_TOP_UA), .y_o(fout_y)
  );

  // Position feedback to position output loop current
  amioc_lmap u_pout (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .x_i(position_fb_i), .in_lo_i(pos_min_i), .in_hi_i(pos_max_i),
    .out_lo_i(i_low), .out_hi_i(CUR_TOP_UA), .y_o(pout_y)
  );

  // Kinematic triggers: ceiling select input doubles as trigger two
  amioc_trig u_trig (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .arm_i(st_r.state == ST_KIN),
    .trig_i({trigger_three_input_i, force_ceiling_select_i, trigger_one_input_i}),
    .both_i(trig_both_i), .rise_id_i(trig_rise_id_i), .fall_id_i(trig_fall_id_i),
    .launch_o(trig_launch), .id_o(trig_id)
  );

  // Mode selection, command update and status mirroring
  always_comb begin
    st_nxt = st_r;
    st_nxt.nv_save = 1'b0;
    if (!drive_enable_input_i) begin
      st_nxt.state = ST_SLEEP;
    end else begin
      case (cfg_mode_i)
        CFG_FORCE: st_nxt.state = ST_FORCE;
        CFG_POS: st_nxt.state = ST_POS;
        CFG_KIN: st_nxt.state = ST_KIN;
        default: st_nxt.state = ST_SLEEP;
      endcase
    end
    st_nxt.op_mode = amioc_opcode(st_nxt.state);
    // Force command only in analog force mode
    st_nxt.force_cmd = (st_r.state == ST_FORCE) ? fmap_y : VAL_ZERO;
    // Position target follows input only while ceiling select stayed low
    st_nxt.fcs_prev = force_ceiling_select_i;
    if (st_r.state == ST_POS && !force_ceiling_select_i && !st_r.fcs_prev) begin
      st_nxt.pos_tgt = pmap_y;
    end
    // Ceiling taken from input while selected in position mode, held after release until position mode ends, else maximum force
    if (st_r.state == ST_POS && st_r.fcs_prev) begin
      st_nxt.ceiling = smap_y;
    end else if (!st_r.ceil_set) begin
      st_nxt.ceiling = force_max_i;
    end
    st_nxt.ceil_set = (st_r.state == ST_POS) && (st_r.ceil_set || st_r.fcs_prev);
    st_nxt.pos_lim = amioc_clip(pos_force_demand_i, st_r.ceiling);
    // Output loops and raw link value
    st_nxt.f_loop = fout_y;
    st_nxt.p_loop = pout_y;
    st_nxt.link_cur = input_current_ua_i;
    st_nxt.caution = motor_warning_i;
    st_nxt.fault = motor_error_i;
    // Save request on the rising edge of the command
    st_nxt.save_prev = save_cmd_i;
    st_nxt.nv_save = save_cmd_i && !st_r.save_prev;
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st_r <= ST_RESET;
    end else if (clk_en_i) begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  assign op_mode_o = st_r.op_mode;
  assign force_cmd_o = st_r.force_cmd;
  assign position_target_o = st_r.pos_tgt;
  assign force_ceiling_o = st_r.ceiling;
  assign pos_force_limited_o = st_r.pos_lim;
  assign motion_launch_o = trig_launch;
  assign motion_id_o = trig_id;
  assign force_loop_ua_o = st_r.f_loop;
  assign position_loop_ua_o = st_r.p_loop;
  assign link_current_ua_o = st_r.link_cur;
  assign caution_output_o = st_r.caution;
  assign caution_led_yellow_o = st_r.caution;
  assign fault_output_o = st_r.fault;
  assign fault_led_red_o = st_r.fault;
  assign nv_save_o = st_r.nv_save;

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_sleep;
    clk_en_i && !drive_enable_input_i |=> op_mode_o == OPM_SLEEP;
  endproperty
  a_sleep: assert property (p_sleep) else $error("not asleep with enable low");

  property p_force;
    clk_en_i && drive_enable_input_i && cfg_mode_i == CFG_FORCE |=> op_mode_o == OPM_FORCE;
  endproperty
  a_force: assert property (p_force) else $error("force mode not entered");

  property p_pos;
    clk_en_i && drive_enable_input_i && cfg_mode_i == CFG_POS |=> op_mode_o == OPM_POS;
  endproperty
  a_pos: assert property (p_pos) else $error("position mode not entered");

  property p_kin;
    clk_en_i && drive_enable_input_i && cfg_mode_i == CFG_KIN |=> op_mode_o == OPM_KIN;
  endproperty
  a_kin: assert property (p_kin) else $error("kinematic mode not entered");

  property p_freeze;
    force_ceiling_select_i |=> $stable(position_target_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("position target moved");

  property p_clip;
    clk_en_i && pos_force_demand_i > force_ceiling_o && force_ceiling_o >= VAL_ZERO
      |=> pos_force_limited_o == $past(force_ceiling_o);
  endproperty
  a_clip: assert property (p_clip) else $error("demand not clipped");

  property p_caution;
    clk_en_i |=> caution_output_o == $past(motor_warning_i)
      && caution_led_yellow_o == caution_output_o;
  endproperty
  a_caution: assert property (p_caution) else $error("caution does not follow warning");

  property p_fault;
    clk_en_i && !drive_enable_input_i && motor_error_i |=> fault_output_o && fault_led_red_o;
  endproperty
  a_fault: assert property (p_fault) else $error("fault dropped in sleep");

  property p_link;
    clk_en_i |=> link_current_ua_o == $past(input_current_ua_i);
  endproperty
  a_link: assert property (p_link) else $error("link value altered");

  property p_save;
    clk_en_i && save_cmd_i && !st_r.save_prev ##1 clk_en_i |=> nv_save_o == 1'b0;
  endproperty
  a_save: assert property (p_save) else $error("save pulse too long");

  property p_fcmd_sleep;
    clk_en_i && st_r.state == ST_SLEEP |=> force_cmd_o == VAL_ZERO;
  endproperty
  a_fcmd_sleep: assert property (p_fcmd_sleep) else $error("force command in sleep");

  c_launch: cover property (motion_launch_o && op_mode_o == OPM_KIN);
  c_ceiling: cover property (st_r.ceil_set && force_ceiling_select_i);
  c_save: cover property (nv_save_o);
  c_fault_sleep: cover property (fault_output_o && op_mode_o == OPM_SLEEP);
endmodule : amioc_top
`default_nettype wire

// file: dv/amioc_plc_model.sv
// Host controller model driving the input current loop and digital inputs
`timescale 1ns/10ps
`default_nettype none
module amioc_plc_model
  import amioc_pkg::*;
(
  // Clock
  input wire logic ref_clk_i,
  // Drive towards the block
  output logic trig1_o,
  output logic ceil_sel_o,
  output logic trig3_o,
  output logic enable_o,
  output logic signed [DW-1:0] cur_ua_o
);
  // Power-up levels: asleep, inputs low, loop at zero
  initial begin
    trig1_o = 1'b0;
    ceil_sel_o = 1'b0;
    trig3_o = 1'b0;
    enable_o = 1'b0;
    cur_ua_o = VAL_ZERO;
  end

  // New loop current just after a rising edge
  task automatic set_cur(input logic signed [DW-1:0] v);
    @(posedge ref_clk_i);
    #1 cur_ua_o = v;
  endtask : set_cur

  // Digital input k: 0 trigger one, 1 ceiling select, 2 trigger three, 3 enable
  task automatic set_di(input int k, input logic v);
    if (k == 1 && trig3_o !== 1'b0) begin
      @(posedge ref_clk_i);
      #1 trig3_o = 1'b0;
    end
    @(posedge ref_clk_i);
    #1;
    case (k)
      0: trig1_o = v;
      1: ceil_sel_o = v;
      2: trig3_o = v;
      default: enable_o = v;
    endcase
  endtask : set_di
endmodule : amioc_plc_model
`default_nettype wire

// file: dv/tb_amioc_top.sv
// Self-checking bench of the analog IO mode controller
`timescale 1ns/10ps
`default_nettype none
module tb_amioc_top;
  import amioc_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_n = 1'b0, warn = 1'b0, err = 1'b0, save = 1'b0, low4 = 1'b1, clk_en = 1'b1;
  logic [1:0] cfg_mode = CFG_FORCE;
  logic [NTRIG-1:0] both = 3'h6;
  logic signed [DW-1:0] fmin = -32'sd1000, fmax = 32'sd3000, pmin = 0, pmax = 32'sd16000;
  logic signed [DW-1:0] ffb = 0, pfb = 0, dem = 0;
  wire logic t1, sel, t3, en, launch, caution, yellow, fault, red, nvs;
  wire logic signed [DW-1:0] cur, fcmd, ptgt, ceil, lim, floop, ploop, link;
  wire logic [3:0] opm;
  wire logic [MIDW-1:0] mid;
  int n_fail = 0, n_compared = 0, cyc = 0, n_nv = 0;
  logic [MIDW-1:0] ids[$];
  logic [3:0] exp_m[4] = '{OPM_FORCE, OPM_POS, OPM_KIN, OPM_SLEEP};
  int ft[7][2] = '{'{4000, -1000}, '{12000, 1000}, '{20000, 3000}, '{24000, 3000},
                   '{2000, -1000}, '{8000, 600}, '{16000, 2200}};
  logic [MIDW-1:0] exp_id[9] = '{8'h11, 8'h22, 8'h55, 8'h33, 8'h66, 8'h33, 8'h11, 8'h66, 8'h44};

  // Clock
  always #50 ref_clk_i = ~ref_clk_i;

  amioc_plc_model i_amioc_plc_model (.ref_clk_i(ref_clk_i), .trig1_o(t1), .ceil_sel_o(sel),
    .trig3_o(t3), .enable_o(en), .cur_ua_o(cur));

  amioc_top i_amioc_top (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n), .clk_en_i(clk_en),
    .trigger_one_input_i(t1), .force_ceiling_select_i(sel), .trigger_three_input_i(t3),
    .drive_enable_input_i(en), .input_current_ua_i(cur), .force_fb_i(ffb),
    .position_fb_i(pfb), .pos_force_demand_i(dem), .motor_warning_i(warn),
    .motor_error_i(err), .cfg_mode_i(cfg_mode), .cfg_low_4ma_i(low4), .force_min_i(fmin),
    .force_max_i(fmax), .pos_min_i(pmin), .pos_max_i(pmax), .trig_both_i(both),
    .trig_rise_id_i(24'h332211), .trig_fall_id_i(24'h665544), .save_cmd_i(save),
    .op_mode_o(opm), .force_cmd_o(fcmd), .position_target_o(ptgt), .force_ceiling_o(ceil),
    .pos_force_limited_o(lim), .motion_launch_o(launch), .motion_id_o(mid),
    .force_loop_ua_o(floop), .position_loop_ua_o(ploop), .link_current_ua_o(link),
    .caution_output_o(caution), .caution_led_yellow_o(yellow), .fault_output_o(fault),
    .fault_led_red_o(red), .nv_save_o(nvs));

  // Collect launches and save pulses mid-cycle
  always @(negedge ref_clk_i) begin
    if (launch === 1'b1) ids.push_back(mid);
    if (nvs === 1'b1) n_nv++;
  end

  // Cut a hang short
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick

  task automatic chk_val(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t value %0h expected %0h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  initial begin
    tick(10);
    chk_val(32'(opm), 32'h0);
    rst_n = 1'b1;
    // Every configured mode with enable high, then low
    for (int m = 0; m < 4; m++) begin
      cfg_mode = 2'(m);
      i_amioc_plc_model.set_di(3, 1'b1);
      tick(3);
      chk_val(32'(opm), 32'(exp_m[m]));
      i_amioc_plc_model.set_di(3, 1'b0);
      tick(3);
      chk_val(32'(opm), 32'h0);
    end
    // Force scaling over both current ranges, with clipping
    cfg_mode = CFG_FORCE;
    i_amioc_plc_model.set_di(3, 1'b1);
    for (int i = 0; i < 7; i++) begin
      low4 = (i < 5);
      i_amioc_plc_model.set_cur(ft[i][0]);
      tick(5);
      chk_val(fcmd, ft[i][1]);
      chk_val(link, ft[i][0]);
    end
    // Output loops in the 4-20 range
    low4 = 1'b1;
    ffb = 32'sd1000;
    pfb = 32'sd4000;
    tick(4);
    chk_val(floop, 32'sd12000);
    chk_val(ploop, 32'sd8000);
    ffb = 32'sd5000;
    tick(4);
    chk_val(floop, 32'sd20000);
    // Position target, ceiling and freeze
    cfg_mode = CFG_POS;
    i_amioc_plc_model.set_cur(32'sd24000);
    tick(5);
    chk_val(ptgt, 32'sd16000);
    i_amioc_plc_model.set_cur(32'sd10000);
    tick(5);
    chk_val(ptgt, 32'sd6000);
    i_amioc_plc_model.set_di(1, 1'b1);
    i_amioc_plc_model.set_cur(32'sd12000);
    tick(5);
    chk_val(ceil, 32'sd1500);
    chk_val(ptgt, 32'sd6000);
    dem = 32'sd2000;
    tick(2);
    chk_val(lim, 32'sd1500);
    dem = -32'sd2000;
    tick(2);
    chk_val(lim, -32'sd1500);
    dem = 32'sd500;
    tick(2);
    chk_val(lim, 32'sd500);
    i_amioc_plc_model.set_di(1, 1'b0);
    tick(5);
    chk_val(ptgt, 32'sd8000);
    // Kinematic triggers, rising only on one, both edges on two and three
    cfg_mode = CFG_KIN;
    fmax = 32'sd4000;
    tick(3);
    chk_val(fcmd, 32'h0);
    ids.delete();
    for (int k = 0; k < 3; k++) begin
      i_amioc_plc_model.set_di(k, 1'b1);
      tick(4);
      i_amioc_plc_model.set_di(k, 1'b0);
      tick(4);
    end
    // Trigger one now fires on both edges; edges after sleep are dropped
    both = 3'h7;
    i_amioc_plc_model.set_di(2, 1'b1);
    tick(4);
    i_amioc_plc_model.set_di(0, 1'b1);
    i_amioc_plc_model.set_di(2, 1'b0);
    tick(6);
    i_amioc_plc_model.set_di(0, 1'b0);
    tick(4);
    i_amioc_plc_model.set_di(3, 1'b0);
    i_amioc_plc_model.set_di(0, 1'b1);
    i_amioc_plc_model.set_di(0, 1'b0);
    tick(6);
    chk_val(32'(ids.size()), 32'd9);
    for (int i = 0; i < 9 && i < ids.size(); i++) chk_val(32'(ids[i]), 32'(exp_id[i]));
    chk_val(ceil, 32'sd4000);
    // Warning, error and recovery through sleep
    i_amioc_plc_model.set_di(3, 1'b1);
    warn = 1'b1;
    tick(2);
    chk_bit(caution & yellow, 1'b1);
    warn = 1'b0;
    tick(2);
    chk_bit(caution | yellow, 1'b0);
    err = 1'b1;
    tick(2);
    chk_bit(fault & red, 1'b1);
    i_amioc_plc_model.set_di(3, 1'b0);
    tick(3);
    chk_val(32'(opm), 32'h0);
    chk_bit(fault, 1'b1);
    err = 1'b0;
    tick(2);
    chk_bit(fault | red, 1'b0);
    // Held save request gives one store pulse
    save = 1'b1;
    tick(4);
    save = 1'b0;
    tick(2);
    chk_val(32'(n_nv), 32'd1);
    // Clock enable low freezes every register
    clk_en = 1'b0;
    i_amioc_plc_model.set_cur(32'sd5000);
    tick(3);
    chk_val(link, 32'sd12000);
    clk_en = 1'b1;
    tick(2);
    chk_val(link, 32'sd5000);
    end_sim();
  end
endmodule : tb_amioc_top
`default_nettype wire
